// [rtl/speed_tune_pkg.sv]
// Constants for the speed-loop refinement block: register map, field
// positions, reset values and filter timing. Assumes a 10 MHz mclk.
package speed_tune_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [5:0] OFS_BIAS_LEVEL = 6'h00;
	localparam logic [5:0] OFS_BIAS_WIDTH = 6'h04;
	localparam logic [5:0] OFS_FB_TC = 6'h08;
	localparam logic [5:0] OFS_AT_SW = 6'h0C;
	localparam logic [5:0] OFS_COMP_PCT = 6'h10;
	localparam logic [5:0] OFS_CONTROL = 6'h14;
	localparam logic [5:0] OFS_GAIN_ONE = 6'h18;
	localparam logic [5:0] OFS_GAIN_TWO = 6'h1C;
	localparam logic [5:0] OFS_INT_ONE = 6'h20;
	localparam logic [5:0] OFS_INT_TWO = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	localparam logic [5:0] OFS_FB_OUT = 6'h2C;
	// Reset values
	localparam logic [15:0] RST_BIAS_LEVEL = 16'h0000;
	localparam logic [15:0] RST_BIAS_WIDTH = 16'h0007;
	localparam logic [15:0] RST_FB_TC = 16'h0000;
	localparam logic [15:0] RST_AT_SW = 16'h0010;
	localparam logic [15:0] RST_COMP_PCT = 16'h0064;
	localparam logic [15:0] RST_SPD_GAIN = 16'h0028;
	localparam logic [15:0] RST_INT_TIME = 16'h07D0;
	localparam logic [15:0] RST_POS_GAIN = 16'h0028;
	// Setting limits
	localparam logic [15:0] MAX_BIAS_LEVEL = 16'h01C2;
	localparam logic [15:0] MAX_BIAS_WIDTH = 16'h00FA;
	localparam logic [15:0] MIN_COMP_PCT = 16'h0001;
	localparam logic [15:0] MAX_COMP_PCT = 16'h01F4;
	localparam logic [15:0] NOM_COMP_PCT = 16'h0064;
	// Field positions: second digit of the switch word, control bits
	localparam int AT_DIGIT1_LSB = 4;
	localparam int CTL_POS_MODE = 0;
	localparam int CTL_ALLOC_MODE = 1;
	localparam int CTL_TERM_LSB = 4;
	localparam int CTL_TERM_W = 3;
	localparam int CTL_GSEL_ASSIGNED = 7;
	localparam logic [3:0] DIGIT_COMP_ON = 4'h0;
	localparam logic [3:0] DIGIT_COMP_OFF = 4'h1;
	// Filter time unit 0.01 ms = 10000 ns, clock period 100 ns
	localparam int TC_UNIT_NS = 10000;
	localparam int MCLK_NS = 100;
	localparam int TC_UNIT_CYC = TC_UNIT_NS / MCLK_NS;
	localparam int NUM_TERMS = 8;
endpackage

// [rtl/fb_lowpass.sv]
// First-order low-pass on speed feedback: y += (x - y) / (tc + 1)
// per time unit. Assumes a clock-enable shared with the parent.
`timescale 1ns/100ps
module fb_lowpass
	import speed_tune_pkg::*;
#(
	parameter int W = 24
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] tc,
	input wire logic signed [W-1:0] din,
	output logic signed [W-1:0] dout
);
	typedef struct packed {
		logic [6:0] tick;
		logic signed [W+15:0] acc;
		logic signed [W-1:0] y;
	} lp_type;
	lp_type cur_ff, nxt_ff;
	logic signed [W+16:0] diff;

	// Leaky integrator; division by a multiply-free shift-subtract is
	// traded for a true divide, acceptable at this slow update rate
	always_comb
	begin
		nxt_ff = cur_ff;
		diff = '0;
		if (tc == 16'h0000)
		begin
			nxt_ff.y = din;
			nxt_ff.acc = (W+16)'(din) <<< 16;
		end
		else if (cur_ff.tick == 7'(TC_UNIT_CYC - 1))
		begin
			nxt_ff.tick = 7'h00;
			diff = ((W+17)'(din) <<< 16) - (W+17)'(cur_ff.acc);
			nxt_ff.acc = cur_ff.acc + (W+16)'(diff / $signed({1'b0, tc} + 17'sh1));
			nxt_ff.y = W'(nxt_ff.acc >>> 16);
		end
		else
			nxt_ff.tick = cur_ff.tick + 7'h01;
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
			cur_ff <= '0;
		else if (ce)
			cur_ff <= nxt_ff;
	end

	assign dout = cur_ff.y;
endmodule // fb_lowpass

// [rtl/speed_loop_tune.sv]
// Speed-loop refinement: speed bias injection, feedback filter,
// feedback compensation scaling and two-set gain selection.
// Assumes a Wishbone classic master on mclk and an external gain
// select pin that is asynchronous to mclk.
// Datapath inputs are taken to be on mclk already and are not
// resynchronised; only the terminal pins pass two flops.
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps

// Overview of operation
// - A speed bias of 0 to 450 rpm, reset 0, is held and injected into the speed reference.
// - The bias is added only while the position error exceeds a width of 0 to 250, reset 7.
// - Speed feedback passes a first-order low-pass whose time constant is in 0.01 ms and zero bypasses it.
// - Compensation is on when the switch word's second digit is 0 and off when it is 1.
// - Switch word 0002 enables compensation with online autotuning off.
// - Compensation scales the feedback by a percent where 100 is nominal.
// - Gain select high uses gain set one, low uses gain set two.
// - Gain select is honoured only when assigned to a terminal, else set one stays.
// - Gain select may be assigned to a terminal only when allocation mode is enabled.
module speed_loop_tune
	import speed_tune_pkg::*;
#(
	parameter int SPD_W = 24
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [speed_tune_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [speed_tune_pkg::DATA_W-1:0] wb_dat_i,
	output logic [speed_tune_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [speed_tune_pkg::NUM_TERMS-1:0] input_terminals_n,
	input wire logic signed [SPD_W-1:0] speed_ref_in,
	input wire logic signed [SPD_W-1:0] position_error,
	input wire logic signed [SPD_W-1:0] speed_feedback,
	output logic signed [SPD_W-1:0] speed_ref_out,
	output logic signed [SPD_W-1:0] speed_fb_out,
	output logic [15:0] speed_loop_gain,
	output logic [15:0] speed_integral_time,
	output logic [15:0] position_loop_gain,
	output logic gain_set_two,
	output logic autotune_enable
);
	// All settings, synchronisers and registered outputs in one word
	// so that the clock enable freezes everything at once
	typedef struct packed {
		logic [15:0] bias_level;
		logic [15:0] bias_width;
		logic [15:0] fb_tc;
		logic [15:0] at_sw;
		logic [15:0] comp_pct;
		logic pos_mode;
		logic alloc_mode;
		logic [2:0] term_sel;
		logic gsel_assigned;
		logic [15:0] gain_spd1;
		logic [15:0] gain_pos1;
		logic [15:0] gain_spd2;
		logic [15:0] gain_pos2;
		logic [15:0] int_one;
		logic [15:0] int_two;
		logic [NUM_TERMS-1:0] sync1;
		logic [NUM_TERMS-1:0] sync2;
		logic [DATA_W-1:0] rdata;
		logic ack;
		logic signed [SPD_W-1:0] ref_out;
		logic signed [SPD_W-1:0] fb_out;
		logic [15:0] spd_gain;
		logic [15:0] int_time;
		logic [15:0] pos_gain;
		logic set_two;
		logic at_en;
	} state_type;
	state_type cur_ff, nxt_ff;

	// Combinational helpers, recomputed every cycle
	logic signed [SPD_W-1:0] fb_filt;
	logic signed [SPD_W-1:0] bias_term;
	logic [SPD_W-1:0] err_mag;
	logic comp_on;
	logic bias_on;
	logic gsel_low;
	logic [31:0] wmask;
	logic signed [SPD_W+10:0] comp_prod;
	logic bus_hit;

	// Feedback filter
	// Filtered value feeds both the output and the compensation
	// scaling stage
	fb_lowpass #(
		.W(SPD_W)
	) u_lowpass (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.tc(cur_ff.fb_tc),
		.din(speed_feedback),
		.dout(fb_filt)
	);

	// Byte lane mask from the select lines
	always_comb
	begin
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	end

	// Byte-lane merge so partial writes leave other lanes intact
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [31:0] m);
		merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
	endfunction

	// Out-of-range writes saturate rather than wrap, so a stray large
	// value cannot turn into a small one
	function automatic logic [15:0] clamp16(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo)
			clamp16 = lo;
		else if (v > hi)
			clamp16 = hi;
		else
			clamp16 = v;
	endfunction

	// Datapath decisions
	always_comb
	begin
		// Error magnitude; held unsigned, so even the most negative count
		// gives its true magnitude and does not wrap
		err_mag = position_error[SPD_W-1] ?
			SPD_W'(-position_error) : SPD_W'(position_error);
		bias_on = cur_ff.pos_mode &&
			(err_mag > SPD_W'(cur_ff.bias_width));
		// second digit test; 0002 has digit 0
		comp_on = (cur_ff.at_sw[AT_DIGIT1_LSB+:4] == DIGIT_COMP_ON);
		// only an assigned, synchronised terminal counts
		gsel_low = cur_ff.gsel_assigned &&
			!cur_ff.sync2[cur_ff.term_sel];
		// percent scaling, 100 is nominal
		// Ten bits of the percent suffice, the clamp keeps it at 500
		comp_prod = (SPD_W+11)'(fb_filt) *
			$signed({1'b0, cur_ff.comp_pct[9:0]});
		// bias magnitude takes the sign of the reference
		bias_term = speed_ref_in[SPD_W-1] ?
			-$signed(SPD_W'(cur_ff.bias_level)) :
			$signed(SPD_W'(cur_ff.bias_level));
	end

	// Register writes, reads and outputs
	always_comb
	begin
		nxt_ff = cur_ff;
		// A pending ack blocks a new take, so takes are two cycles apart
		bus_hit = wb_cyc_i && wb_stb_i && !cur_ff.ack;
		nxt_ff.ack = bus_hit;
		// Input pins pass two flops first; they shift only while ce is high
		nxt_ff.sync1 = input_terminals_n;
		nxt_ff.sync2 = cur_ff.sync1;
		// A write lands at the take edge, the same edge that raises the ack
		if (bus_hit && wb_we_i)
		begin
			case (wb_adr_i)
				OFS_BIAS_LEVEL: nxt_ff.bias_level = clamp16(merge16(
					cur_ff.bias_level, wb_dat_i, wmask), 16'h0000,
					MAX_BIAS_LEVEL);
				OFS_BIAS_WIDTH: nxt_ff.bias_width = clamp16(merge16(
					cur_ff.bias_width, wb_dat_i, wmask), 16'h0000,
					MAX_BIAS_WIDTH);
				// Filter constant and switch word take any value
				OFS_FB_TC: nxt_ff.fb_tc =
					merge16(cur_ff.fb_tc, wb_dat_i, wmask);
				OFS_AT_SW: nxt_ff.at_sw =
					merge16(cur_ff.at_sw, wb_dat_i, wmask);
				OFS_COMP_PCT: nxt_ff.comp_pct = clamp16(merge16(
					cur_ff.comp_pct, wb_dat_i, wmask), MIN_COMP_PCT,
					MAX_COMP_PCT);
				// Control bits live in the low byte only
				OFS_CONTROL:
				begin
					if (wb_sel_i[0])
					begin
						nxt_ff.pos_mode = wb_dat_i[CTL_POS_MODE];
						nxt_ff.alloc_mode = wb_dat_i[CTL_ALLOC_MODE];
						nxt_ff.term_sel =
							wb_dat_i[CTL_TERM_LSB+:CTL_TERM_W];
						nxt_ff.gsel_assigned =
							wb_dat_i[CTL_GSEL_ASSIGNED] &&
							wb_dat_i[CTL_ALLOC_MODE];
					end
				end
				// Gain words pack speed gain low, position gain high
				OFS_GAIN_ONE:
				begin
					nxt_ff.gain_spd1 = merge16(cur_ff.gain_spd1,
						wb_dat_i, wmask);
					nxt_ff.gain_pos1 = merge16(cur_ff.gain_pos1,
						wb_dat_i >> 16, wmask >> 16);
				end
				OFS_GAIN_TWO:
				begin
					nxt_ff.gain_spd2 = merge16(cur_ff.gain_spd2,
						wb_dat_i, wmask);
					nxt_ff.gain_pos2 = merge16(cur_ff.gain_pos2,
						wb_dat_i >> 16, wmask >> 16);
				end
				// Integral times, one per gain set
				OFS_INT_ONE: nxt_ff.int_one =
					merge16(cur_ff.int_one, wb_dat_i, wmask);
				OFS_INT_TWO: nxt_ff.int_two =
					merge16(cur_ff.int_two, wb_dat_i, wmask);
				default: ;
			endcase
		end
		// Read mux; unmapped offsets read zero but are still acked
		case (wb_adr_i)
			OFS_BIAS_LEVEL: nxt_ff.rdata = {16'h0000, cur_ff.bias_level};
			OFS_BIAS_WIDTH: nxt_ff.rdata = {16'h0000, cur_ff.bias_width};
			OFS_FB_TC: nxt_ff.rdata = {16'h0000, cur_ff.fb_tc};
			OFS_AT_SW: nxt_ff.rdata = {16'h0000, cur_ff.at_sw};
			OFS_COMP_PCT: nxt_ff.rdata = {16'h0000, cur_ff.comp_pct};
			OFS_CONTROL: nxt_ff.rdata = {24'h000000,
				cur_ff.gsel_assigned, cur_ff.term_sel, 2'b00,
				cur_ff.alloc_mode, cur_ff.pos_mode};
			OFS_GAIN_ONE: nxt_ff.rdata = {cur_ff.gain_pos1,
				cur_ff.gain_spd1};
			OFS_GAIN_TWO: nxt_ff.rdata = {cur_ff.gain_pos2,
				cur_ff.gain_spd2};
			OFS_INT_ONE: nxt_ff.rdata = {16'h0000, cur_ff.int_one};
			OFS_INT_TWO: nxt_ff.rdata = {16'h0000, cur_ff.int_two};
			// Status and feedback words are read-only
			OFS_STATUS: nxt_ff.rdata = {28'h0000000, cur_ff.at_en,
				comp_on, bias_on, cur_ff.set_two};
			OFS_FB_OUT: nxt_ff.rdata = 32'(cur_ff.fb_out);
			default: nxt_ff.rdata = 32'h00000000;
		endcase
		if (bias_on)
			nxt_ff.ref_out = speed_ref_in + bias_term;
		else
			nxt_ff.ref_out = speed_ref_in;
		// scaled feedback when compensation is on
		// Signed divide so negative feedback scales symmetrically
		if (comp_on)
			nxt_ff.fb_out = SPD_W'(comp_prod /
				$signed((SPD_W+11)'(NOM_COMP_PCT)));
		else
			nxt_ff.fb_out = fb_filt;
		// gain set choice
		// All three gains switch on the same edge, never a mixed set
		nxt_ff.set_two = gsel_low;
		nxt_ff.spd_gain = gsel_low ? cur_ff.gain_spd2 : cur_ff.gain_spd1;
		nxt_ff.int_time = gsel_low ? cur_ff.int_two : cur_ff.int_one;
		nxt_ff.pos_gain = gsel_low ? cur_ff.gain_pos2 : cur_ff.gain_pos1;
		// lowest digit 2 turns autotuning off
		nxt_ff.at_en = (cur_ff.at_sw[3:0] == 4'h0);
	end

	// State register; settings take their factory values at reset
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cur_ff <= '0;
			cur_ff.bias_level <= RST_BIAS_LEVEL;
			cur_ff.bias_width <= RST_BIAS_WIDTH;
			cur_ff.fb_tc <= RST_FB_TC;
			cur_ff.at_sw <= RST_AT_SW;
			cur_ff.comp_pct <= RST_COMP_PCT;
			cur_ff.gain_spd1 <= RST_SPD_GAIN;
			cur_ff.gain_spd2 <= RST_SPD_GAIN;
			cur_ff.gain_pos1 <= RST_POS_GAIN;
			cur_ff.gain_pos2 <= RST_POS_GAIN;
			cur_ff.int_one <= RST_INT_TIME;
			cur_ff.int_two <= RST_INT_TIME;
			// Synchronisers start at the idle high level so no false
			// select appears just after reset
			cur_ff.sync1 <= '1;
			cur_ff.sync2 <= '1;
			cur_ff.spd_gain <= RST_SPD_GAIN;
			cur_ff.int_time <= RST_INT_TIME;
			cur_ff.pos_gain <= RST_POS_GAIN;
			cur_ff.at_en <= 1'b1;
		end
		else if (ce)
			cur_ff <= nxt_ff;
	end

	// Outputs are the register fields directly, no logic after them
	assign wb_dat_o = cur_ff.rdata;
	assign wb_ack_o = cur_ff.ack;
	assign speed_ref_out = cur_ff.ref_out;
	assign speed_fb_out = cur_ff.fb_out;
	assign speed_loop_gain = cur_ff.spd_gain;
	assign speed_integral_time = cur_ff.int_time;
	assign position_loop_gain = cur_ff.pos_gain;
	assign gain_set_two = cur_ff.set_two;
	assign autotune_enable = cur_ff.at_en;
endmodule // speed_loop_tune

// [test/speed_tune_props.sv]
// Port checker for speed_loop_tune: bus handshake, bias and gains.
// Bound from the bench onto the design top; sees its ports only.
`timescale 1ns/100ps
module speed_tune_props
	import speed_tune_pkg::*;
#(
	parameter int SPD_W = 24
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [speed_tune_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [speed_tune_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic signed [SPD_W-1:0] speed_ref_in,
	input wire logic signed [SPD_W-1:0] position_error,
	input wire logic signed [SPD_W-1:0] speed_ref_out,
	input wire logic signed [SPD_W-1:0] speed_fb_out,
	input wire logic [15:0] speed_loop_gain,
	input wire logic [15:0] speed_integral_time,
	input wire logic [15:0] position_loop_gain,
	input wire logic gain_set_two,
	input wire logic autotune_enable
);
	logic take;
	logic rds;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A request is taken only while no ack is pending
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	assign rds = take && !wb_we_i && wb_adr_i == OFS_STATUS;
	a_ack_answer: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
		else $error("ack without request");
	a_no_bias: assert property (ce && position_error == '0
		|=> speed_ref_out == $past(speed_ref_in))
		else $error("bias added with zero error");
	a_reset_gains: assert property ($fell(rst) |->
		speed_loop_gain == RST_SPD_GAIN && speed_integral_time == RST_INT_TIME
		&& position_loop_gain == RST_POS_GAIN && !gain_set_two)
		else $error("gain outputs wrong after reset");
	a_ce_freeze: assert property (!ce |=> $stable(speed_ref_out)
		&& $stable(speed_fb_out) && $stable(wb_ack_o))
		else $error("outputs moved while frozen");
	a_gains_hold: assert property ((!wb_cyc_i && $stable(gain_set_two))[*3]
		|-> $stable(speed_loop_gain) && $stable(position_loop_gain))
		else $error("gains moved without cause");
	a_status_mirror: assert property (rds ##1 $stable(gain_set_two)
		|-> wb_dat_o[0] == gain_set_two)
		else $error("status set bit differs from output");
	// Main scenarios reached
	cover property (take && wb_we_i);
	cover property ($rose(gain_set_two));
	cover property (ce && position_error != '0);
endmodule // speed_tune_props

// [test/gain_host_model.sv]
// Host controller model: drives the gain select level on one terminal.
// Terminals it does not use rest at their pull-up, inactive high.
`timescale 1ns/100ps
module gain_host_model
	import speed_tune_pkg::*;
(
	input wire logic mclk,
	input wire logic [2:0] term,
	input wire logic sel_two,
	output logic [speed_tune_pkg::NUM_TERMS-1:0] terminals_n
);
	// Level may change at any edge, running or stopped; the unused
	// terminals rest high in the same single assignment
	always @(posedge mclk)
	begin
		terminals_n <= ~(NUM_TERMS'(sel_two) << term);
	end
endmodule // gain_host_model

// [test/speed_loop_tune_bench.sv]
// Self-checking bench for speed_loop_tune over Wishbone classic.
// Assumes package, design, host model and checker compiled first.
`timescale 1ns/100ps
module speed_loop_tune_bench;
	import speed_tune_pkg::*;
	logic mclk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, sel_two;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, q;
	logic [2:0] term;
	logic signed [23:0] speed_ref_in, position_error, speed_feedback;
	wire logic [31:0] wb_dat_o;
	wire logic wb_ack_o, gain_set_two, autotune_enable;
	wire logic [7:0] input_terminals_n;
	wire logic signed [23:0] speed_ref_out, speed_fb_out;
	wire logic [15:0] speed_loop_gain, speed_integral_time, position_loop_gain;
	int n_errors, samples_checked;
	speed_loop_tune #(.SPD_W(24)) uut (
		.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .input_terminals_n(input_terminals_n),
		.speed_ref_in(speed_ref_in), .position_error(position_error),
		.speed_feedback(speed_feedback), .speed_ref_out(speed_ref_out),
		.speed_fb_out(speed_fb_out), .speed_loop_gain(speed_loop_gain),
		.speed_integral_time(speed_integral_time),
		.position_loop_gain(position_loop_gain),
		.gain_set_two(gain_set_two), .autotune_enable(autotune_enable));
	gain_host_model hm (.mclk(mclk), .term(term), .sel_two(sel_two),
		.terminals_n(input_terminals_n));
	// Compare and count
	task automatic chk(input string s, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// One classic cycle; held until ack is sampled
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			n_errors++;
			$display("[FAIL] wb_ack_o expected 1 seen %b", wb_ack_o);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input string s, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask
	// Datapath inputs, then let the registered outputs settle
	task automatic dp(input int r, e, f);
		@(posedge mclk);
		speed_ref_in <= 24'(r);
		position_error <= 24'(e);
		speed_feedback <= 24'(f);
		repeat (4) @(posedge mclk);
	endtask
	task automatic t_reset_and_clamp;
		rd("bias", OFS_BIAS_LEVEL, RST_BIAS_LEVEL);
		rd("width", OFS_BIAS_WIDTH, RST_BIAS_WIDTH);
		rd("tc", OFS_FB_TC, RST_FB_TC);
		rd("switch", OFS_AT_SW, RST_AT_SW);
		rd("pct", OFS_COMP_PCT, RST_COMP_PCT);
		rd("gain1", OFS_GAIN_ONE, {RST_POS_GAIN, RST_SPD_GAIN});
		bus(1'b1, 6'h30, 32'hFFFF);
		rd("unmapped", 6'h30, 32'h0);
		bus(1'b1, OFS_BIAS_LEVEL, 32'hFFFF);
		rd("bias_max", OFS_BIAS_LEVEL, MAX_BIAS_LEVEL);
		bus(1'b1, OFS_BIAS_WIDTH, 32'hFFFF);
		rd("width_max", OFS_BIAS_WIDTH, MAX_BIAS_WIDTH);
		bus(1'b1, OFS_COMP_PCT, 32'h0);
		rd("pct_min", OFS_COMP_PCT, MIN_COMP_PCT);
	endtask
	// Bias only beyond the width and only in position mode
	task automatic t_bias;
		bus(1'b1, OFS_BIAS_WIDTH, 32'h7);
		bus(1'b1, OFS_CONTROL, 32'h1);
		dp(100, 8, 0);
		chk("bias_on", 550, speed_ref_out);
		dp(100, 7, 0);
		chk("at_width", 100, speed_ref_out);
		dp(-100, -8, 0);
		chk("bias_neg", -550, speed_ref_out);
		bus(1'b1, OFS_CONTROL, 32'h0);
		dp(100, 8, 0);
		chk("speed_mode", 100, speed_ref_out);
		@(posedge mclk);
		ce <= 1'b0;
		repeat (3) @(posedge mclk);
		ce <= 1'b1;
	endtask
	task automatic t_gain;
		bus(1'b1, OFS_GAIN_ONE, 32'h0011_0022);
		bus(1'b1, OFS_GAIN_TWO, 32'h0033_0044);
		bus(1'b1, OFS_INT_ONE, 32'h55);
		bus(1'b1, OFS_INT_TWO, 32'h66);
		@(posedge mclk);
		term <= 3'd3;
		sel_two <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("unassigned", 16'h22, speed_loop_gain);
		bus(1'b1, OFS_CONTROL, 32'hB0);
		repeat (6) @(posedge mclk);
		chk("no_alloc", 1'b0, gain_set_two);
		rd("ctl", OFS_CONTROL, 32'h30);
		bus(1'b1, OFS_CONTROL, 32'hB2);
		repeat (6) @(posedge mclk);
		chk("set2", 32'h0044_0033, {speed_loop_gain, position_loop_gain});
		chk("int2", 16'h66, speed_integral_time);
		rd("status", OFS_STATUS, 32'h9);
		@(posedge mclk);
		sel_two <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("set1", 32'h0022_0011, {speed_loop_gain, position_loop_gain});
		chk("int1", 16'h55, speed_integral_time);
	endtask
	task automatic t_feedback;
		dp(0, 0, 1000);
		chk("fb_plain", 1000, speed_fb_out);
		bus(1'b1, OFS_AT_SW, 32'h2);
		bus(1'b1, OFS_COMP_PCT, 32'd90);
		dp(0, 0, 1000);
		chk("fb_comp", 900, speed_fb_out);
		chk("autotune", 1'b0, autotune_enable);
		bus(1'b1, OFS_AT_SW, 32'h12);
		dp(0, 0, 1000);
		chk("fb_std", 1000, speed_fb_out);
		rd("fb_reg", OFS_FB_OUT, 32'd1000);
		bus(1'b1, OFS_FB_TC, 32'h1);
		dp(0, 0, 2000);
		repeat (300) @(posedge mclk);
		chk("fb_lag", 1, speed_fb_out > 1000 && speed_fb_out < 2000);
	endtask
	// Reset in mid-run restores the factory settings
	task automatic t_midreset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("gain_rst", RST_SPD_GAIN, speed_loop_gain);
		chk("at_rst", 1'b1, autotune_enable);
		rd("bias_rst", OFS_BIAS_LEVEL, RST_BIAS_LEVEL);
		rd("pct_rst", OFS_COMP_PCT, RST_COMP_PCT);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Free-running 10 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		end_of_test();
	end
	// Reset, then each scenario in turn
	initial
	begin
		{rst, ce, wb_sel_i} = 6'h3F;
		{wb_cyc_i, wb_stb_i, wb_we_i, sel_two, term} = 7'h00;
		{wb_adr_i, wb_dat_i} = 38'h0;
		{speed_ref_in, position_error, speed_feedback} = 72'h0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_reset_and_clamp();
		t_bias();
		t_gain();
		t_feedback();
		t_midreset();
		end_of_test();
	end
endmodule // speed_loop_tune_bench
bind speed_loop_tune speed_tune_props #(.SPD_W(SPD_W)) props_i (
	.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.speed_ref_in(speed_ref_in), .position_error(position_error),
	.speed_ref_out(speed_ref_out), .speed_fb_out(speed_fb_out),
	.speed_loop_gain(speed_loop_gain),
	.speed_integral_time(speed_integral_time),
	.position_loop_gain(position_loop_gain),
	.gain_set_two(gain_set_two), .autotune_enable(autotune_enable));
